//--- rtl/thermal_throttle_timer_alert.sv
// Throttle pin timer, limit flag, alert and overtemperature drive
`timescale 1ns/1ns
`include "throttle_consts.svh"

module thermal_throttle_timer_alert
  import throttle_pkg::*;
#(
  parameter int TICK_CYCLES = `TIMER_LSB_CYCLES
)
(
  // Clock and reset
  input  wire logic                CORE_CLK_IN,
  input  wire logic                RST_IN,
  // Register access
  input  wire reg_req_t            REG_REQ_IN,
  output logic [7:0]               REG_RDATA_OUT,
  // Throttle pins: bit 0 dedicated, bit 1 shared
  input  wire logic [1:0]          THROTTLE_PIN_IN,
  output logic [1:0]               THROTTLE_PIN_OUT,
  output logic [1:0]               THROTTLE_PIN_OE_OUT,
  // Temperatures: 0 remote one, 1 local, 2 remote two
  input  wire temp_report_t [2:0]  TEMP_REPORT_IN,
  input  wire logic                TEMP_TWOS_MODE_IN,
  // Fan control
  input  wire logic                FAN_RUNNING_IN,
  input  wire logic                MANUAL_MODE_IN,
  output logic                     FAN_FORCE_OUT,
  output logic                     FAN_FORCE_MAX_DUTY_OUT,
  // Alert request, active high
  output logic                     ALERT_OUT
);

  logic [7:0]  fan_override_config_reg;
  logic [7:0]  hysteresis_config_reg;
  logic [7:0]  crit_limit_reg [3];
  logic [7:0]  alert_mask_one_reg;
  logic [7:0]  alert_mask_two_reg;
  logic [7:0]  timer_and_boost_config_reg;
  logic [7:0]  assertion_timer_limit_reg;
  logic [7:0]  channel_output_enable_reg;
  logic [7:0]  shared_pin_event_config_reg;

  logic [1:0]  pin_meta_reg;
  logic [1:0]  pin_sync_reg;
  logic [2:0]  over_reg;
  logic [31:0] sub_count_reg;
  logic [7:0]  ticks_reg;
  logic        seen_reg;
  logic        flag_reg;

  logic        wr;
  logic        timer_rd;
  logic        status_rd;
  logic        mon_en;
  logic [1:0]  pin_func;
  logic        shared_is_throttle;
  logic        asserted;
  logic [7:0]  timer_val;
  logic        exceeded;
  logic        mask_sel;
  logic        drive_ok;
  logic        drive_low;
  logic        force_next;

  assign wr        = REG_REQ_IN.wr;
  assign timer_rd  = REG_REQ_IN.rd && (REG_REQ_IN.addr == `ASSERTION_TIMER_ADDR);
  assign status_rd = REG_REQ_IN.rd && (REG_REQ_IN.addr == `STATUS_TWO_ADDR);

  // Register writes
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      fan_override_config_reg     <= `CONFIG_RESET;
      hysteresis_config_reg       <= `CONFIG_RESET;
      crit_limit_reg[0]           <= `CONFIG_RESET;
      crit_limit_reg[1]           <= `CONFIG_RESET;
      crit_limit_reg[2]           <= `CONFIG_RESET;
      alert_mask_one_reg          <= `CONFIG_RESET;
      alert_mask_two_reg          <= `CONFIG_RESET;
      timer_and_boost_config_reg  <= `CONFIG_RESET;
      assertion_timer_limit_reg   <= `CONFIG_RESET;
      channel_output_enable_reg   <= `CONFIG_RESET;
      shared_pin_event_config_reg <= `CONFIG_RESET;
    end
    else if (wr)
    begin
      case (REG_REQ_IN.addr)
        `FAN_OVERRIDE_CONFIG_ADDR:     fan_override_config_reg     <= REG_REQ_IN.wdata;
        `HYSTERESIS_CONFIG_ADDR:       hysteresis_config_reg       <= REG_REQ_IN.wdata;
        `REMOTE_ONE_CRIT_LIMIT_ADDR:   crit_limit_reg[0]           <= REG_REQ_IN.wdata;
        `LOCAL_CRIT_LIMIT_ADDR:        crit_limit_reg[1]           <= REG_REQ_IN.wdata;
        `REMOTE_TWO_CRIT_LIMIT_ADDR:   crit_limit_reg[2]           <= REG_REQ_IN.wdata;
        `ALERT_MASK_ONE_ADDR:          alert_mask_one_reg          <= REG_REQ_IN.wdata;
        `ALERT_MASK_TWO_ADDR:          alert_mask_two_reg          <= REG_REQ_IN.wdata;
        `TIMER_AND_BOOST_CONFIG_ADDR:  timer_and_boost_config_reg  <= REG_REQ_IN.wdata;
        `ASSERTION_TIMER_LIMIT_ADDR:   assertion_timer_limit_reg   <= REG_REQ_IN.wdata;
        `CHANNEL_OUTPUT_ENABLE_ADDR:   channel_output_enable_reg   <= REG_REQ_IN.wdata;
        `SHARED_PIN_EVENT_CONFIG_ADDR: shared_pin_event_config_reg <= REG_REQ_IN.wdata;
        default:                       ;
      endcase
    end
  end

  // Register reads; data appears the edge after the read strobe
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      REG_RDATA_OUT <= 8'h00;
    else if (REG_REQ_IN.rd)
    begin
      case (REG_REQ_IN.addr)
        `FAN_OVERRIDE_CONFIG_ADDR:     REG_RDATA_OUT <= fan_override_config_reg;
        `HYSTERESIS_CONFIG_ADDR:       REG_RDATA_OUT <= hysteresis_config_reg;
        `REMOTE_ONE_CRIT_LIMIT_ADDR:   REG_RDATA_OUT <= crit_limit_reg[0];
        `LOCAL_CRIT_LIMIT_ADDR:        REG_RDATA_OUT <= crit_limit_reg[1];
        `REMOTE_TWO_CRIT_LIMIT_ADDR:   REG_RDATA_OUT <= crit_limit_reg[2];
        `ALERT_MASK_ONE_ADDR:          REG_RDATA_OUT <= alert_mask_one_reg;
        `ALERT_MASK_TWO_ADDR:          REG_RDATA_OUT <= alert_mask_two_reg;
        `TIMER_AND_BOOST_CONFIG_ADDR:  REG_RDATA_OUT <= timer_and_boost_config_reg;
        `ASSERTION_TIMER_ADDR:         REG_RDATA_OUT <= timer_val;
        `ASSERTION_TIMER_LIMIT_ADDR:   REG_RDATA_OUT <= assertion_timer_limit_reg;
        `CHANNEL_OUTPUT_ENABLE_ADDR:   REG_RDATA_OUT <= channel_output_enable_reg;
        `SHARED_PIN_EVENT_CONFIG_ADDR: REG_RDATA_OUT <= shared_pin_event_config_reg;
        `STATUS_TWO_ADDR:              REG_RDATA_OUT <= {2'h0, flag_reg, 5'h00};
        default:                       REG_RDATA_OUT <= 8'h00;
      endcase
    end
  end

  // Pin function and timer enable
  assign mon_en             = timer_and_boost_config_reg[`TIMER_ENABLE_BIT];
  assign pin_func           = shared_pin_event_config_reg[`PIN_FUNC_LSB +: 2];
  assign shared_is_throttle = mon_en && (pin_func == `PIN_FUNC_THROTTLE);

  // Two-stage synchronisers on both candidate pins
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      pin_meta_reg <= 2'h3;
      pin_sync_reg <= 2'h3;
    end
    else
    begin
      pin_meta_reg <= THROTTLE_PIN_IN;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Pin is active low; our own drive also counts as an assertion
  assign asserted = (mon_en && !pin_sync_reg[0]) || (shared_is_throttle && !pin_sync_reg[1]);

  // Low timer codes: bit 0 marks a first assertion until two steps pass
  assign timer_val = (ticks_reg < 8'h02) ? {7'h00, seen_reg} : ticks_reg;

  // Accumulating timer, cleared by a read of the timer register
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      sub_count_reg <= 32'h0;
      ticks_reg     <= 8'h00;
      seen_reg      <= 1'b0;
    end
    else if (timer_rd)
    begin
      // Read during an assertion restarts at the first-assertion code
      sub_count_reg <= 32'h0;
      ticks_reg     <= 8'h00;
      seen_reg      <= asserted;
    end
    else if (asserted && ticks_reg != `TIMER_FULL_SCALE)
    begin
      seen_reg <= 1'b1;
      if (sub_count_reg == 32'(TICK_CYCLES - 1))
      begin
        sub_count_reg <= 32'h0;
        ticks_reg     <= ticks_reg + 8'h01;
      end
      else
        sub_count_reg <= sub_count_reg + 32'h1;
    end
  end

  // Combinational compare tracks every timer change
  assign exceeded = timer_val > assertion_timer_limit_reg;

  // Sticky flag: set wins over the read-clear
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      flag_reg <= 1'b0;
    else if (exceeded)
      flag_reg <= 1'b1;
    else if (status_rd)
      flag_reg <= 1'b0;
  end

  // Mask bit depends on which pin carries the timer input
  assign mask_sel = (pin_func == `PIN_FUNC_THROTTLE) ? alert_mask_two_reg[`MASK_TWO_TIMER_BIT]
                                                     : alert_mask_one_reg[`MASK_ONE_TIMER_BIT];

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      ALERT_OUT <= 1'b0;
    else
      ALERT_OUT <= flag_reg && !mask_sel;
  end

  // Overtemperature compare per channel, once per result
  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++)
    begin : g_chan
      logic [9:0] temp_key;
      logic [9:0] limit_key;
      logic       limit_off;
      // Two's complement maps onto the unsigned scale by flipping the sign
      assign temp_key  = TEMP_TWOS_MODE_IN ? {~TEMP_REPORT_IN[ch].value[9], TEMP_REPORT_IN[ch].value[8:0]}
                                           : TEMP_REPORT_IN[ch].value;
      assign limit_key = TEMP_TWOS_MODE_IN ? {~crit_limit_reg[ch][7], crit_limit_reg[ch][6:0], 2'h0}
                                           : {crit_limit_reg[ch], 2'h0};
      assign limit_off = TEMP_TWOS_MODE_IN ? (crit_limit_reg[ch] == `TWOS_DISABLE_CODE)
                                           : (crit_limit_reg[ch] <= `OFFSET64_DISABLE_MAX);

      always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
      begin
        if (RST_IN)
          over_reg[ch] <= 1'b0;
        else if (TEMP_REPORT_IN[ch].done)
          over_reg[ch] <= channel_output_enable_reg[`CHANNEL_ENABLE_LSB + ch]
                          && !limit_off
                          && (temp_key > limit_key);
      end
    end
  endgenerate

  // Disable bit blocks the drive only while hysteresis is on
  assign drive_ok  = !(shared_pin_event_config_reg[`EVENT_DISABLE_BIT]
                       && !hysteresis_config_reg[`HYSTERESIS_OFF_BIT]);
  assign drive_low = drive_ok && (|over_reg);

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      THROTTLE_PIN_OUT    <= 2'h0;
      THROTTLE_PIN_OE_OUT <= 2'h0;
    end
    else
    begin
      THROTTLE_PIN_OUT    <= 2'h0;
      THROTTLE_PIN_OE_OUT <= {drive_low && shared_is_throttle, drive_low && mon_en};
    end
  end

  // Fan boost on throttle assertion
  assign force_next = asserted
                      && timer_and_boost_config_reg[`BOOST_ENABLE_BIT]
                      && FAN_RUNNING_IN
                      && !shared_pin_event_config_reg[`EVENT_DISABLE_BIT]
                      && (!MANUAL_MODE_IN || fan_override_config_reg[`MANUAL_OVERRIDE_BIT]);

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      FAN_FORCE_OUT          <= 1'b0;
      FAN_FORCE_MAX_DUTY_OUT <= 1'b0;
    end
    else
    begin
      FAN_FORCE_OUT          <= force_next;
      FAN_FORCE_MAX_DUTY_OUT <= shared_pin_event_config_reg[`EVENT_DUTY_SELECT_BIT];
    end
  end

  // Checks
  AST_FLAG_ON_EXCEED: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    exceeded |=> flag_reg)
    else $error("flag not set after timer exceeded limit");

  AST_FIRST_ASSERTION: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    ($rose(seen_reg) && assertion_timer_limit_reg == 8'h00) |=> flag_reg)
    else $error("zero limit did not flag first assertion");

  AST_LIMIT_ONE: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (assertion_timer_limit_reg == 8'h01 && ticks_reg < 8'h02) |-> !exceeded)
    else $error("limit one exceeded before two steps");

  AST_MASKED_ALERT: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (flag_reg && mask_sel) |=> !ALERT_OUT)
    else $error("masked flag still raised the alert");

  AST_UNMASKED_ALERT: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (flag_reg && !mask_sel) |=> ALERT_OUT)
    else $error("unmasked flag did not raise the alert");

  AST_MONITOR_OFF: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (!mon_en && !timer_rd) |=> ($stable(ticks_reg) && $stable(sub_count_reg)))
    else $error("timer moved while monitoring disabled");

  AST_SATURATE: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (ticks_reg == `TIMER_FULL_SCALE && !timer_rd) |=> ticks_reg == `TIMER_FULL_SCALE)
    else $error("timer left full scale without a read");

  AST_READ_CLEARS: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    timer_rd |=> (ticks_reg == 8'h00 && sub_count_reg == 32'h0))
    else $error("timer read did not clear the timer");

  AST_STOPPED_FANS: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    !FAN_RUNNING_IN |=> !FAN_FORCE_OUT)
    else $error("stopped fans were forced");

  AST_MANUAL_MODE: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (MANUAL_MODE_IN && !fan_override_config_reg[`MANUAL_OVERRIDE_BIT]) |=> !FAN_FORCE_OUT)
    else $error("manual mode forced without override");

  AST_EVENT_DISABLE: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    shared_pin_event_config_reg[`EVENT_DISABLE_BIT] |=> !FAN_FORCE_OUT)
    else $error("event disable did not block fan force");

  AST_HOLD_CYCLE: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (over_reg[0] && !TEMP_REPORT_IN[0].done) |=> over_reg[0])
    else $error("overtemperature dropped between results");

  AST_HYST_BLOCK: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (shared_pin_event_config_reg[`EVENT_DISABLE_BIT] && !hysteresis_config_reg[`HYSTERESIS_OFF_BIT])
      |=> THROTTLE_PIN_OE_OUT == 2'h0)
    else $error("pin driven with hysteresis on and function disabled");

  AST_LIMIT_DISABLED: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (TEMP_REPORT_IN[0].done && !TEMP_TWOS_MODE_IN && crit_limit_reg[0] <= `OFFSET64_DISABLE_MAX)
      |=> !over_reg[0])
    else $error("disabled limit still tripped remote one");

  AST_TWOS_DISABLED: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (TEMP_REPORT_IN[0].done && TEMP_TWOS_MODE_IN && crit_limit_reg[0] == `TWOS_DISABLE_CODE)
      |=> !over_reg[0])
    else $error("lowest twos limit still tripped remote one");

  AST_AT_LIMIT_RELEASE: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    (TEMP_REPORT_IN[0].done && !TEMP_TWOS_MODE_IN && TEMP_REPORT_IN[0].value <= {crit_limit_reg[0], 2'h0})
      |=> !over_reg[0])
    else $error("remote one held over at or below its limit");

  AST_SHARED_DRIVE: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    !shared_is_throttle |=> !THROTTLE_PIN_OE_OUT[1])
    else $error("shared pin driven without throttle function");

endmodule

//--- common/throttle_consts.svh
// Register map, field positions, reset values and timing for the throttle block
`ifndef THROTTLE_CONSTS_SVH
`define THROTTLE_CONSTS_SVH

// Register byte offsets
`define FAN_OVERRIDE_CONFIG_ADDR      8'h10
`define HYSTERESIS_CONFIG_ADDR        8'h11
`define REMOTE_ONE_CRIT_LIMIT_ADDR    8'h6a
`define LOCAL_CRIT_LIMIT_ADDR         8'h6b
`define REMOTE_TWO_CRIT_LIMIT_ADDR    8'h6c
`define ALERT_MASK_ONE_ADDR           8'h74
`define ALERT_MASK_TWO_ADDR           8'h75
`define TIMER_AND_BOOST_CONFIG_ADDR   8'h78
`define ASSERTION_TIMER_ADDR          8'h79
`define ASSERTION_TIMER_LIMIT_ADDR    8'h7a
`define CHANNEL_OUTPUT_ENABLE_ADDR    8'h7c
`define SHARED_PIN_EVENT_CONFIG_ADDR  8'h7d
`define STATUS_TWO_ADDR               8'h3f

// Field positions
`define BOOST_ENABLE_BIT              2
`define TIMER_ENABLE_BIT              1
`define TIMER_LIMIT_FLAG_BIT          5
`define MASK_TWO_TIMER_BIT            5
`define MASK_ONE_TIMER_BIT            0
`define MANUAL_OVERRIDE_BIT           3
`define HYSTERESIS_OFF_BIT            0
`define EVENT_DUTY_SELECT_BIT         3
`define EVENT_DISABLE_BIT             2
`define CHANNEL_ENABLE_LSB            5
`define PIN_FUNC_LSB                  0

// Shared pin function codes
`define PIN_FUNC_TACH                 2'h0
`define PIN_FUNC_THROTTLE             2'h1
`define PIN_FUNC_ALERT                2'h2
`define PIN_FUNC_GPIO                 2'h3

// Reset value and timer full scale
`define CONFIG_RESET                  8'h00
`define TIMER_FULL_SCALE              8'hff

// Critical limit disable codes
`define OFFSET64_DISABLE_MAX          8'h01
`define TWOS_DISABLE_CODE             8'h80

// Timing: timer weight and core clock period
`define TIMER_LSB_NS                  22760000
`define CLK_PERIOD_NS                 50
`define TIMER_LSB_CYCLES              (`TIMER_LSB_NS / `CLK_PERIOD_NS)

`endif

//--- common/throttle_pkg.sv
// Types shared by the throttle timer and alert block
package throttle_pkg;

  // One register access from the serial interface engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // One temperature result; value is quarter degrees
  typedef struct packed {
    logic       done;
    logic [9:0] value;
  } temp_report_t;

endpackage

//--- testbench/hot_signal_model.sv
// Far-side model: processor hot signal sharing the open-drain throttle pins
`timescale 1ns/1ns

module hot_signal_model
(
  // Processor hot requests, high pulls that pin low
  input  wire logic [1:0] hot_in,
  // Device drive enables
  input  wire logic [1:0] dev_oe_in,
  // Resolved wire levels
  output logic [1:0]      level_out
);
  // Pull-up wins only when neither party pulls low
  assign level_out = ~(hot_in | dev_oe_in);
endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the throttle timer and alert block
`timescale 1ns/1ns
`include "throttle_consts.svh"
`define CHECK_EQ(what, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("BAD %s expected %h seen %h", what, exp, got); \
    end \
  end

module tb_top;
  import throttle_pkg::*;
  // Short timer step keeps the saturation run affordable
  localparam int TICK = 8;
  localparam int LIMIT_CYCLES = 10000;
  logic               clk;
  logic               rst;
  reg_req_t           req;
  logic [7:0]         rdata;
  logic [1:0]         pin_level;
  logic [1:0]         pin_out;
  logic [1:0]         pin_oe;
  temp_report_t [2:0] temp;
  logic               twos;
  logic               fan_running;
  logic               manual;
  logic               force_out;
  logic               max_duty;
  logic               alert;
  logic [1:0]         cpu_hot;
  int                 n_mismatch;
  int                 samples_checked;
  int                 cycles;
  logic [7:0]         addr_tbl [11] = '{`FAN_OVERRIDE_CONFIG_ADDR, `HYSTERESIS_CONFIG_ADDR,
    `REMOTE_ONE_CRIT_LIMIT_ADDR, `LOCAL_CRIT_LIMIT_ADDR, `REMOTE_TWO_CRIT_LIMIT_ADDR, `ALERT_MASK_ONE_ADDR,
    `ALERT_MASK_TWO_ADDR, `TIMER_AND_BOOST_CONFIG_ADDR, `ASSERTION_TIMER_LIMIT_ADDR,
    `CHANNEL_OUTPUT_ENABLE_ADDR, `SHARED_PIN_EVENT_CONFIG_ADDR};

  thermal_throttle_timer_alert #(.TICK_CYCLES(TICK)) thermal_throttle_timer_alert_i
  (
    .CORE_CLK_IN            (clk),
    .RST_IN                 (rst),
    .REG_REQ_IN             (req),
    .REG_RDATA_OUT          (rdata),
    .THROTTLE_PIN_IN        (pin_level),
    .THROTTLE_PIN_OUT       (pin_out),
    .THROTTLE_PIN_OE_OUT    (pin_oe),
    .TEMP_REPORT_IN         (temp),
    .TEMP_TWOS_MODE_IN      (twos),
    .FAN_RUNNING_IN         (fan_running),
    .MANUAL_MODE_IN         (manual),
    .FAN_FORCE_OUT          (force_out),
    .FAN_FORCE_MAX_DUTY_OUT (max_duty),
    .ALERT_OUT              (alert)
  );

  hot_signal_model hot_signal_model_i
  (
    .hot_in    (cpu_hot),
    .dev_oe_in (pin_oe),
    .level_out (pin_level)
  );

  initial clk = 1'b0;
  always #25 clk = ~clk;

  task automatic results;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT_CYCLES)
    begin
      n_mismatch++;
      results();
    end
  end

  // Inputs always move 5 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    step(1);
    req = '0;
    // Idle cycle so back-to-back calls never rewrite the strobe in one step
    step(1);
  endtask

  task automatic check_reg(input logic [7:0] a, input logic [7:0] exp, input string what);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    step(1);
    req = '0;
    step(1);
    `CHECK_EQ(what, exp, rdata)
  endtask

  task automatic report(input int ch, input logic [9:0] v);
    temp[ch] = '{done: 1'b1, value: v};
    step(1);
    temp[ch].done = 1'b0;
    step(1);
  endtask

  task automatic boost_case(input logic run, input logic man, input logic [7:0] c10, input logic [7:0] c7d,
                            input logic [7:0] c78, input logic exp);
    fan_running = run;
    manual = man;
    reg_write(`FAN_OVERRIDE_CONFIG_ADDR, c10);
    reg_write(`SHARED_PIN_EVENT_CONFIG_ADDR, c7d);
    reg_write(`TIMER_AND_BOOST_CONFIG_ADDR, c78);
    cpu_hot = 2'b01;
    step(6);
    `CHECK_EQ("fan force", exp, force_out)
    `CHECK_EQ("max duty", c7d[`EVENT_DUTY_SELECT_BIT], max_duty)
    cpu_hot = 2'b00;
    step(6);
    `CHECK_EQ("force release", 1'b0, force_out)
  endtask

  initial
  begin
    rst = 1'b1;
    req = '0;
    temp = '0;
    twos = 1'b0;
    fan_running = 1'b0;
    manual = 1'b0;
    cpu_hot = 2'b00;
    n_mismatch = 0;
    samples_checked = 0;
    cycles = 0;
    step(2);
    rst = 1'b0;
    step(1);
    foreach (addr_tbl[i]) check_reg(addr_tbl[i], `CONFIG_RESET, "reset value");
    check_reg(8'h20, 8'h00, "unmapped");
    foreach (addr_tbl[i]) reg_write(addr_tbl[i], 8'ha5 ^ 8'(i));
    foreach (addr_tbl[i]) check_reg(addr_tbl[i], 8'ha5 ^ 8'(i), "readback");
    foreach (addr_tbl[i]) reg_write(addr_tbl[i], 8'h00);
    reg_write(`ASSERTION_TIMER_ADDR, 8'h55);
    // Monitoring off: pin activity is ignored
    cpu_hot = 2'b01;
    step(20);
    cpu_hot = 2'b00;
    check_reg(`ASSERTION_TIMER_ADDR, 8'h00, "timer off");
    `CHECK_EQ("alert off", 1'b0, alert)
    reg_write(`TIMER_AND_BOOST_CONFIG_ADDR, 8'h02);
    cpu_hot = 2'b01;
    step(6);
    `CHECK_EQ("alert limit zero", 1'b1, alert)
    cpu_hot = 2'b00;
    step(4);
    reg_write(`ALERT_MASK_ONE_ADDR, 8'h01);
    step(2);
    `CHECK_EQ("alert masked", 1'b0, alert)
    check_reg(`STATUS_TWO_ADDR, 8'h20, "flag masked");
    check_reg(`ASSERTION_TIMER_ADDR, 8'h01, "first assertion");
    check_reg(`ASSERTION_TIMER_ADDR, 8'h00, "timer cleared");
    check_reg(`STATUS_TWO_ADDR, 8'h20, "flag read");
    check_reg(`STATUS_TWO_ADDR, 8'h00, "flag cleared");
    reg_write(`ALERT_MASK_ONE_ADDR, 8'h00);
    // Shared pin uses the other mask bit
    reg_write(`SHARED_PIN_EVENT_CONFIG_ADDR, 8'h01);
    reg_write(`ALERT_MASK_TWO_ADDR, 8'h20);
    cpu_hot = 2'b10;
    step(6);
    cpu_hot = 2'b00;
    `CHECK_EQ("shared masked", 1'b0, alert)
    check_reg(`STATUS_TWO_ADDR, 8'h20, "shared flag");
    reg_write(`ALERT_MASK_TWO_ADDR, 8'h00);
    step(2);
    `CHECK_EQ("shared unmasked", 1'b1, alert)
    check_reg(`ASSERTION_TIMER_ADDR, 8'h01, "shared timer");
    check_reg(`STATUS_TWO_ADDR, 8'h20, "shared clear");
    step(1);
    `CHECK_EQ("alert cleared", 1'b0, alert)
    reg_write(`SHARED_PIN_EVENT_CONFIG_ADDR, 8'h00);
    reg_write(`ASSERTION_TIMER_LIMIT_ADDR, 8'h01);
    cpu_hot = 2'b01;
    step(12);
    `CHECK_EQ("limit one early", 1'b0, alert)
    step(14);
    `CHECK_EQ("limit one late", 1'b1, alert)
    cpu_hot = 2'b00;
    step(4);
    // Pin counted for 26 cycles: three whole steps
    check_reg(`ASSERTION_TIMER_ADDR, 8'h03, "three steps");
    check_reg(`STATUS_TWO_ADDR, 8'h20, "limit one flag");
    repeat (2)
    begin
      cpu_hot = 2'b01;
      step(4 * TICK);
      cpu_hot = 2'b00;
      step(10);
    end
    reg_write(`ASSERTION_TIMER_LIMIT_ADDR, 8'h00);
    check_reg(`ASSERTION_TIMER_ADDR, 8'h08, "accumulate");
    cpu_hot = 2'b01;
    step(260 * TICK);
    cpu_hot = 2'b00;
    step(4);
    check_reg(`ASSERTION_TIMER_ADDR, `TIMER_FULL_SCALE, "saturate");
    boost_case(1'b1, 1'b0, 8'h00, 8'h00, 8'h06, 1'b1);
    boost_case(1'b1, 1'b0, 8'h00, 8'h00, 8'h02, 1'b0);
    boost_case(1'b0, 1'b0, 8'h00, 8'h00, 8'h06, 1'b0);
    boost_case(1'b1, 1'b1, 8'h00, 8'h00, 8'h06, 1'b0);
    boost_case(1'b1, 1'b1, 8'h08, 8'h00, 8'h06, 1'b1);
    boost_case(1'b1, 1'b0, 8'h00, 8'h04, 8'h06, 1'b0);
    boost_case(1'b1, 1'b0, 8'h00, 8'h08, 8'h06, 1'b1);
    fan_running = 1'b0;
    reg_write(`SHARED_PIN_EVENT_CONFIG_ADDR, 8'h00);
    reg_write(`TIMER_AND_BOOST_CONFIG_ADDR, 8'h02);
    for (int i = 0; i < 3; i++) reg_write(addr_tbl[i + 2], 8'h50);
    for (int ch = 0; ch < 3; ch++)
    begin
      reg_write(`CHANNEL_OUTPUT_ENABLE_ADDR, 8'(8'h20 << ch));
      report(ch, 10'h140);
      `CHECK_EQ("at limit", 2'b00, pin_oe)
      report((ch + 1) % 3, 10'h141);
      `CHECK_EQ("other channel", 2'b00, pin_oe)
      report((ch + 1) % 3, 10'h140);
      report(ch, 10'h141);
      `CHECK_EQ("over limit", 2'b01, pin_oe)
      step(8);
      `CHECK_EQ("held between", 2'b01, pin_oe)
      report(ch, 10'h141);
      `CHECK_EQ("held low", 2'b01, pin_oe)
      report(ch, 10'h140);
      `CHECK_EQ("released", 2'b00, pin_oe)
    end
    reg_write(`CHANNEL_OUTPUT_ENABLE_ADDR, 8'h20);
    reg_write(`REMOTE_ONE_CRIT_LIMIT_ADDR, `OFFSET64_DISABLE_MAX);
    report(0, 10'h3ff);
    `CHECK_EQ("offset64 off", 2'b00, pin_oe)
    twos = 1'b1;
    reg_write(`REMOTE_ONE_CRIT_LIMIT_ADDR, `TWOS_DISABLE_CODE);
    report(0, 10'h004);
    `CHECK_EQ("twos off", 2'b00, pin_oe)
    reg_write(`REMOTE_ONE_CRIT_LIMIT_ADDR, 8'h81);
    report(0, 10'h004);
    `CHECK_EQ("twos on", 2'b01, pin_oe)
    report(0, 10'h204);
    `CHECK_EQ("twos release", 2'b00, pin_oe)
    twos = 1'b0;
    reg_write(`REMOTE_ONE_CRIT_LIMIT_ADDR, 8'h50);
    reg_write(`SHARED_PIN_EVENT_CONFIG_ADDR, 8'h04);
    report(0, 10'h141);
    `CHECK_EQ("hysteresis on", 2'b00, pin_oe)
    reg_write(`HYSTERESIS_CONFIG_ADDR, 8'h01);
    report(0, 10'h141);
    `CHECK_EQ("hysteresis off", 2'b01, pin_oe)
    report(0, 10'h140);
    reg_write(`SHARED_PIN_EVENT_CONFIG_ADDR, 8'h01);
    report(0, 10'h141);
    `CHECK_EQ("both pins", 2'b11, pin_oe)
    `CHECK_EQ("pin level", 2'b00, pin_out)
    results();
  end
endmodule
